// ==== logic/psb_pkg.sv ====
package psb_pkg;

  // ==========================================================
  // geometry
  localparam int ADDR_W_DEF  = 10;  // default word address width
  localparam int LANES_DEF   = 4;   // byte lanes
  localparam int LANE_W      = 9;   // eight data bits plus parity bit
  localparam int BURST_LEN   = 4;   // burst wraps over two low address bits
  localparam int BURST_W     = 2;

  // ==========================================================
  // pipeline timing
  localparam int DATA_LAT    = 2;   // enabled edges from command to data

  // ==========================================================
  // reset values
  localparam logic [1:0] BURST_RST = 2'h0;

  // command carried through the pipeline
  typedef struct packed {
    logic        valid;   // selected, real operation
    logic        write;   // write when set, read when clear
    logic [31:0] addr;    // word address, upper bits unused
    logic [7:0]  lanes_n; // byte lane write selects, active low
  } psb_cmd_type;

endpackage

// ==== logic/psb_sram.sv ====
`timescale 1ns/100ps
module psb_sram
  import psb_pkg::*;
#(
  parameter int ADDR_W = ADDR_W_DEF,
  parameter int LANES  = LANES_DEF
) (
  input  wire logic                    CLK_SYS,
  input  wire logic                    RST_B,
  input  wire logic                    CLOCK_QUALIFY_N,
  input  wire logic [ADDR_W-1:0]       ADDR,
  input  wire logic                    WRITE_EN_N,
  input  wire logic [LANES-1:0]        BYTE_LANE_WRITE_SEL_N,
  input  wire logic                    SELECT_LOW_FIRST,
  input  wire logic                    SELECT_HIGH_SECOND,
  input  wire logic                    SELECT_LOW_THIRD,
  input  wire logic                    ADVANCE_OR_LOAD,
  input  wire logic                    BURST_INTERLEAVED,
  input  wire logic                    OUTPUT_EN_N,
  input  wire logic                    SLEEP_REQUEST,
  input  wire logic [LANES*LANE_W-1:0] DQ_IN,
  output logic      [LANES*LANE_W-1:0] DQ_OUT,
  output logic      [LANES*LANE_W-1:0] DQ_OE,
  output logic                         SLEEPING
);

  localparam int DW = LANES*LANE_W;

  // ==========================================================
  // burst address order
  function automatic logic [BURST_W-1:0] burst_step(input logic [BURST_W-1:0] base,
                                                     input logic [BURST_W-1:0] cnt,
                                                     input logic               ilv);
    burst_step = ilv ? (base ^ cnt) : (base + cnt);
  endfunction

  // ==========================================================
  // input registers, every input sampled on the rising edge
  logic              cen_n_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic              we_n_reg;
  logic [LANES-1:0]  bw_n_reg;
  logic              sel_reg;
  logic              adv_reg;
  logic              ilv_reg;
  logic              zz_reg;
  logic [DW-1:0]     din_reg;
  logic              oe_n_s1_reg;
  logic              oe_n_reg;

  // pin capture; both levels of the output enable synchroniser
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      cen_n_reg   <= 1'b1;
      addr_reg    <= '0;
      we_n_reg    <= 1'b1;
      bw_n_reg    <= '1;
      sel_reg     <= 1'b0;
      adv_reg     <= 1'b0;
      ilv_reg     <= 1'b0;
      zz_reg      <= 1'b0;
      din_reg     <= '0;
      oe_n_s1_reg <= 1'b1;
      oe_n_reg    <= 1'b1;
    end else begin
      cen_n_reg   <= CLOCK_QUALIFY_N;
      addr_reg    <= ADDR;
      we_n_reg    <= WRITE_EN_N;
      bw_n_reg    <= BYTE_LANE_WRITE_SEL_N;
      sel_reg     <= !SELECT_LOW_FIRST && SELECT_HIGH_SECOND && !SELECT_LOW_THIRD;
      adv_reg     <= ADVANCE_OR_LOAD;
      ilv_reg     <= BURST_INTERLEAVED;
      zz_reg      <= SLEEP_REQUEST;
      din_reg     <= DQ_IN;
      oe_n_s1_reg <= OUTPUT_EN_N;
      oe_n_reg    <= oe_n_s1_reg;
    end
  end

  // enabled edge: state below moves only when qualified, except SLEEPING and the DQ_OE clear on output disable
  logic run;
  assign run = !cen_n_reg && !zz_reg;

  // ==========================================================
  // command decode and burst tracking
  psb_cmd_type       cmd_now;
  logic              last_valid_reg;
  logic              last_write_reg;
  logic [ADDR_W-1:0] base_reg;
  logic [BURST_W-1:0] cnt_reg;
  logic [BURST_W-1:0] cnt_next;

  assign cnt_next = cnt_reg + 1'b1;

  // new command on load, continuation on advance
  always_comb begin
    cmd_now = '0;
    if (adv_reg) begin
      cmd_now.valid   = last_valid_reg;
      cmd_now.write   = last_write_reg;
      cmd_now.addr[ADDR_W-1:0] = {base_reg[ADDR_W-1:BURST_W],
                                  burst_step(base_reg[BURST_W-1:0], cnt_next, ilv_reg)};
    end else begin
      cmd_now.valid   = sel_reg;
      cmd_now.write   = !we_n_reg;
      cmd_now.addr[ADDR_W-1:0] = addr_reg;
    end
    cmd_now.lanes_n[LANES-1:0] = bw_n_reg;
    if (LANES < 8) cmd_now.lanes_n[7:LANES] = '1;
  end

  // burst state follows loads and advances
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      last_valid_reg <= 1'b0;
      last_write_reg <= 1'b0;
      base_reg       <= '0;
      cnt_reg        <= BURST_RST;
    end else if (run) begin
      if (adv_reg) begin
        cnt_reg <= cnt_next;
      end else begin
        last_valid_reg <= sel_reg;
        last_write_reg <= !we_n_reg;
        base_reg       <= addr_reg;
        cnt_reg        <= BURST_RST;
      end
    end
  end

  // ==========================================================
  // two-stage command pipeline, no turnaround gaps
  psb_cmd_type pipe_reg [DATA_LAT];

  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      for (int i = 0; i < DATA_LAT; i++) begin
        pipe_reg[i] <= '0;
      end
    end else if (run) begin
      pipe_reg[0] <= cmd_now;
      for (int i = 1; i < DATA_LAT; i++) begin
        pipe_reg[i] <= pipe_reg[i-1];
      end
    end
  end

  psb_cmd_type data_cmd;
  assign data_cmd = pipe_reg[DATA_LAT-1];

  // ==========================================================
  // storage array
  logic [DW-1:0] mem [1 << ADDR_W];

  // self-timed write of the selected lanes in the data phase
  always_ff @(posedge CLK_SYS) begin
    if (run && data_cmd.valid && data_cmd.write) begin
      for (int b = 0; b < LANES; b++) begin
        if (!data_cmd.lanes_n[b]) begin
          mem[data_cmd.addr[ADDR_W-1:0]][b*LANE_W +: LANE_W] <= din_reg[b*LANE_W +: LANE_W];
        end
      end
    end
  end

  // ==========================================================
  // output registers and self-timed driver enable
  logic rd_phase;
  assign rd_phase = data_cmd.valid && !data_cmd.write;

  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      DQ_OUT <= '0;
    end else if (run && rd_phase) begin
      DQ_OUT <= mem[data_cmd.addr[ADDR_W-1:0]];
    end
  end

  // drivers on only in read phases with output enable asserted
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      DQ_OE <= '0;
    end else if (oe_n_reg) begin
      DQ_OE <= '0;
    end else if (run) begin
      DQ_OE <= {DW{rd_phase}};
    end
  end

  // sleep status
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      SLEEPING <= 1'b0;
    end else begin
      SLEEPING <= zz_reg;
    end
  end

  // one operation per enabled edge, no stall path exists

endmodule

// ==== test/psb_ctrl_model.sv ====
`timescale 1ns/100ps
// ====
// controller write data path
module psb_ctrl_model
  import psb_pkg::*;
(
  input wire logic clk,
  input wire logic wv,
  input wire logic [LANES_DEF*LANE_W-1:0] wd,
  output logic [LANES_DEF*LANE_W-1:0] dq
);
  logic v_reg = 1'b0;
  logic [LANES_DEF*LANE_W-1:0] d_reg = 36'h0;
  logic [LANES_DEF*LANE_W-1:0] q_reg = 36'h0;
  assign dq = q_reg;
  // data trails its command by two edges; a released bus shows the inverse
  always_ff @(posedge clk) begin
    v_reg <= wv;
    d_reg <= wd;
    q_reg <= v_reg ? d_reg : ~q_reg;
  end
endmodule

// ==== test/psb_sram_properties.sv ====
`timescale 1ns/100ps
// ====
// port checks
module psb_sram_properties
  import psb_pkg::*;
#(parameter int ADDR_W = ADDR_W_DEF, parameter int LANES = LANES_DEF) (
  input wire logic CLK_SYS,
  input wire logic RST_B,
  input wire logic CLOCK_QUALIFY_N,
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic WRITE_EN_N,
  input wire logic [LANES-1:0] BYTE_LANE_WRITE_SEL_N,
  input wire logic SELECT_LOW_FIRST,
  input wire logic SELECT_HIGH_SECOND,
  input wire logic SELECT_LOW_THIRD,
  input wire logic ADVANCE_OR_LOAD,
  input wire logic BURST_INTERLEAVED,
  input wire logic OUTPUT_EN_N,
  input wire logic SLEEP_REQUEST,
  input wire logic [LANES*LANE_W-1:0] DQ_IN,
  input wire logic [LANES*LANE_W-1:0] DQ_OUT,
  input wire logic [LANES*LANE_W-1:0] DQ_OE,
  input wire logic SLEEPING
);
  default clocking @(posedge CLK_SYS);
  endclocking
  default disable iff (!RST_B);
  // command decode at the pins
  wire sel = !SELECT_LOW_FIRST && SELECT_HIGH_SECOND && !SELECT_LOW_THIRD;
  wire run = !CLOCK_QUALIFY_N && !SLEEP_REQUEST;
  wire on = run && !OUTPUT_EN_N;
  wire rd = sel && !ADVANCE_OR_LOAD && WRITE_EN_N && on;
  wire wr = sel && !ADVANCE_OR_LOAD && !WRITE_EN_N && run;
  // output timing
  stall_hold_a: assert property (CLOCK_QUALIFY_N |-> ##2 $stable(DQ_OUT) && $stable(DQ_OE))
    else $error("stall moved outputs");
  sleep_hold_a: assert property (SLEEP_REQUEST |-> ##2 $stable(DQ_OUT) && $stable(DQ_OE))
    else $error("sleep moved outputs");
  sleep_flag_a: assert property (SLEEP_REQUEST [*4] |-> SLEEPING)
    else $error("no sleep flag");
  oe_float_a: assert property (OUTPUT_EN_N [*4] |-> DQ_OE == '0)
    else $error("driving while disabled");
  read_drive_a: assert property (rd ##1 on [*2] |-> ##2 &DQ_OE)
    else $error("read not driven");
  write_float_a: assert property (wr ##1 run [*2] |-> ##2 DQ_OE == '0)
    else $error("driving in write");
  deselect_idle_a: assert property ((!sel && !ADVANCE_OR_LOAD && run) ##1 run [*2] |-> ##2 DQ_OE == '0)
    else $error("deselected drove");
  burst_drive_a: assert property (rd ##1 (ADVANCE_OR_LOAD && on) ##1 on [*2] |-> ##2 &DQ_OE)
    else $error("burst not driven");
  cover property (rd ##1 ADVANCE_OR_LOAD);
  cover property (!WRITE_EN_N ##1 rd);
  cover property (SLEEPING);
endmodule
bind psb_sram psb_sram_properties #(.ADDR_W(ADDR_W), .LANES(LANES)) u_props (.*);

// ==== test/psb_sram_tb.sv ====
`timescale 1ns/100ps
// ====
// bench
module psb_sram_tb;
  import psb_pkg::*;
  localparam int W = LANES_DEF * LANE_W;
  localparam logic [2:0] ON = 3'h2;
  localparam logic [W-1:0] MSK = {9'h1ff, 9'h0, 9'h1ff, 9'h0};
  logic clk = 0, rst_b = 0, qn = 0, we_n = 1, s1 = 1, s2 = 0, s3 = 1, adv = 0, ilv = 0, oe_n = 0, sr = 0, wv = 0;
  logic slp;
  logic [9:0] a = 10'h0;
  logic [3:0] ln = 4'h0;
  logic [W-1:0] wd = 36'h0, di, dout, doe;
  int errors = 0, comparisons = 0;
  `define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin errors++; $display("MISMATCH %s exp %h got %h", n, e, g); end end
  psb_sram DUT (.CLK_SYS(clk), .RST_B(rst_b), .CLOCK_QUALIFY_N(qn), .ADDR(a), .WRITE_EN_N(we_n),
    .BYTE_LANE_WRITE_SEL_N(ln), .SELECT_LOW_FIRST(s1), .SELECT_HIGH_SECOND(s2), .SELECT_LOW_THIRD(s3),
    .ADVANCE_OR_LOAD(adv), .BURST_INTERLEAVED(ilv), .OUTPUT_EN_N(oe_n), .SLEEP_REQUEST(sr), .DQ_IN(di),
    .DQ_OUT(dout), .DQ_OE(doe), .SLEEPING(slp));
  psb_ctrl_model CTL (.clk(clk), .wv(wv), .wd(wd), .dq(di));
  initial forever #50 clk = ~clk;
  // ====
  // helpers
  function automatic logic [W-1:0] pat(input int x);
    return {LANES_DEF{x[8:0]}};
  endfunction
  task automatic cmd(input logic v, w, input logic [2:0] s, input int x, input logic [W-1:0] d, input logic [3:0] m);
    @(posedge clk);
    {s1, s2, s3} <= s;
    adv <= v;
    we_n <= !w;
    a <= x[9:0];
    wd <= d;
    ln <= m;
    wv <= w && s == ON;
  endtask
  task automatic rd(input int x, input logic [W-1:0] e);
    cmd(0, 0, ON, x, 36'h0, 4'h0);
    cmd(0, 0, 3'h6, 0, 36'h0, 4'h0);
    repeat (3) @(posedge clk);
    #1;
    `CHK("read data", e, dout)
  endtask
  // ====
  // scenarios
  task automatic t_write;
    cmd(0, 1, ON, 5, '1, 4'h0);
    cmd(0, 1, ON, 5, 36'h0, 4'ha);
    for (int i = 0; i < 4; i++) cmd(i > 0, 1, ON, 8, pat(8 + i), 4'h0);
    rd(5, MSK);
    for (int i = 0; i < 3; i++) begin
      cmd(0, 1, ON ^ (3'h4 >> i), 5, 36'h0, 4'h0);
      rd(5, MSK);
    end
  endtask
  task automatic t_burst;
    for (int m = 0; m < 2; m++) begin
      @(posedge clk);
      ilv <= m[0];
      for (int i = 0; i < 4; i++) cmd(i > 0, 0, ON, 9, 36'h0, 4'h0);
      cmd(0, 0, 3'h6, 0, 36'h0, 4'h0);
      for (int i = 0; i < 4; i++) begin
        #1;
        `CHK("burst beat", pat(m ? 8 + (1 ^ i) : 8 + ((1 + i) & 3)), dout)
        @(posedge clk);
      end
    end
  endtask
  task automatic t_stall;
    cmd(0, 0, ON, 11, 36'h0, 4'h0);
    cmd(0, 0, 3'h6, 0, 36'h0, 4'h0);
    qn <= 1;
    repeat (2) @(posedge clk);
    qn <= 0;
    repeat (2) @(posedge clk);
    #1;
    `CHK("stalled slot", 36'h0, doe)
    @(posedge clk);
    #1;
    `CHK("stalled read", pat(11), dout)
    `CHK("stalled drive", {W{1'b1}}, doe)
  endtask
  task automatic t_idle;
    cmd(0, 0, ON, 10, 36'h0, 4'h0);
    oe_n <= 1;
    cmd(0, 0, 3'h6, 0, 36'h0, 4'h0);
    repeat (3) @(posedge clk);
    #1;
    `CHK("floated", 36'h0, doe)
    @(posedge clk);
    oe_n <= 0;
    sr <= 1;
    repeat (4) @(posedge clk);
    #1;
    `CHK("sleep flag", 1'b1, slp)
    @(posedge clk);
    sr <= 0;
    repeat (4) @(posedge clk);
    #1;
    `CHK("awake flag", 1'b0, slp)
  endtask
  task automatic print_verdict;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // main sequence and watchdog
  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1;
    t_write;
    t_burst;
    t_stall;
    t_idle;
    print_verdict;
  end
  initial begin
    repeat (3000) @(posedge clk);
    errors++;
    print_verdict;
  end
endmodule
